/* mon_regs_pkg.sv */
package mon_regs_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_RESULT_READY  = 5'h00;
   localparam logic [4:0] ADDR_CHANNEL_STATE = 5'h01;
   localparam logic [4:0] ADDR_PAIRS_ONE_TWO = 5'h06;
   localparam logic [4:0] ADDR_PAIRS_3_4     = 5'h07;
   localparam logic [4:0] ADDR_PWM_DIE       = 5'h08;
   localparam logic [4:0] ADDR_RESULT_FIRST  = 5'h0A;
   localparam logic [4:0] ADDR_RESULT_LAST   = 5'h1D;
   localparam logic [7:0] REG_RESET          = 8'h00;
   localparam int         ADDR_USED_BITS     = 5;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CH_PAIR_EN_LSB = 4;
   localparam int CH_DIE_EN      = 3;
   localparam int CH_BUSY        = 2;
   localparam int CH_DIE_TEMP_NEW = 1;
   localparam int CH_SUPPLY_NEW  = 0;
   localparam int PC_UPPER_BASE  = 4;
   localparam int PC_FILT        = 3;
   localparam int PC_KELVIN      = 2;
   localparam int PC_TEMP        = 1;
   localparam int PC_DIFF        = 0;
   localparam int PW_THR_LSB     = 7;
   localparam int PW_INVERT      = 6;
   localparam int PW_ENABLE      = 5;
   localparam int PW_REPEAT      = 4;
   localparam int PW_DIE_FILT    = 3;
   localparam int PW_DIE_KELVIN  = 2;
   localparam logic [7:0] PW_WRITE_MASK  = 8'hFC;
   localparam logic [7:0] CH_WRITE_MASK  = 8'hF8;

   // ------------------------------------------------------------
   // PWM
   // ------------------------------------------------------------
   localparam logic [8:0] PWM_PERIOD_MAX = 9'h1FF;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_DIFF   = 2'b01,
      MODE_TEMP   = 2'b10
   } pair_mode_e;

   typedef struct packed {
      logic       filter_en;
      logic       kelvin;
      pair_mode_e mode;
   } pair_cfg_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_s;

endpackage

/* pair_decode.sv */
`timescale 1ns/1ps
module pair_decode (
   // Raw nibble of a pair-control register
   input  wire logic [3:0]              nibble,
   // Decoded configuration
   output      mon_regs_pkg::pair_cfg_s cfg
);

   always_comb begin
      cfg.filter_en = nibble[mon_regs_pkg::PC_FILT];
      cfg.kelvin    = nibble[mon_regs_pkg::PC_KELVIN];
      if (nibble[mon_regs_pkg::PC_TEMP]) begin
         cfg.mode = mon_regs_pkg::MODE_TEMP;
      end else if (nibble[mon_regs_pkg::PC_DIFF]) begin
         cfg.mode = mon_regs_pkg::MODE_DIFF;
      end else begin
         cfg.mode = mon_regs_pkg::MODE_SINGLE;
      end
   end

endmodule

/* pwm_gen.sv */
`timescale 1ns/1ps
module pwm_gen (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Control
   input  wire logic       enable,
   input  wire logic       invert,
   input  wire logic [8:0] threshold,
   input  wire logic [8:0] temp_level,
   // Pin
   output      logic       pwm_out
);

   logic [8:0] cnt_ff;
   logic [8:0] nxt_cnt;
   logic       pwm_ff;
   logic       nxt_pwm;
   logic       raw;

   always_comb begin
      nxt_cnt = (cnt_ff == mon_regs_pkg::PWM_PERIOD_MAX) ? 9'h000 : cnt_ff + 9'h001;
      // Duty grows with temperature above the threshold
      raw = enable && (temp_level > threshold) &&
            (cnt_ff < (temp_level - threshold));
      nxt_pwm = raw ^ invert;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_ff <= 9'h000;
         pwm_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         pwm_ff <= nxt_pwm;
      end
   end

   assign pwm_out = pwm_ff;

endmodule

/* mon_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - Register address decode uses only the low five address bits.
// - Any write to the channel-enable register starts a conversion.
// - Every register clears to zero at reset.
// - Low status holds one new-data flag per input result, bit n input n+1.
// - Channel-enable bits 4..7 enable input pairs one through four.
// - Channel-enable bit 3 enables die temperature and supply measurement.
// - Channel-enable bit 2 reads one while converting.
// - Bits 1 and 0 flag new die temperature and supply data.
// - Pair-control bits 3 and 7 enable filtering per pair.
// - Pair-control bits 2 and 6 select Kelvin or Celsius per pair.
// - Pair-control bits 1 and 5 select remote-diode temperature.
// - Pair-control bits 0 and 4 select differential or single-ended.
// - PWM control bit 7 holds threshold least significant bit.
// - PWM control bit 6 inverts the PWM output.
// - Noninverted PWM duty rises with temperature.
// - PWM control bit 5 enables the PWM output.
// - PWM control bit 4 selects repeated rather than single-shot acquisition.
// - PWM control bits 3 and 2 set die filter and Kelvin.
// - Result flag sets on new result, clears when its MSB byte register (even address) is addressed.
// - In repeated mode busy stays high after the first trigger.
// - Disabled PWM pin rests low, or high when inverted.
module mon_regs (
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   // Host register access
   input  wire mon_regs_pkg::host_req_s   host_req,
   output      logic [7:0]                rdata,
   // Conversion engine
   input  wire logic [7:0]                result_written,
   input  wire logic                      die_temp_written,
   input  wire logic                      supply_written,
   input  wire logic                      conv_done,
   input  wire logic [8:0]                pwm_temp_level,
   input  wire logic [7:0]                pwm_thr_msb,
   output      logic                      conv_start,
   output      logic                      conv_busy,
   output      logic                      repeat_mode,
   output      logic [3:0]                pair_enable,
   output      logic                      die_enable,
   output      logic                      die_filter_en,
   output      logic                      die_kelvin,
   output      mon_regs_pkg::pair_cfg_s   pair_cfg [4],
   // PWM pin
   output      logic                      pwm_out
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] ready_ff,    nxt_ready;
   logic [7:0] chan_ff,     nxt_chan;
   logic [7:0] pcfg_a_ff,   nxt_pcfg_a;
   logic [7:0] pcfg_b_ff,   nxt_pcfg_b;
   logic [7:0] pwmc_ff,     nxt_pwmc;
   logic       die_new_ff,  nxt_die_new;
   logic       sup_new_ff,  nxt_sup_new;
   logic       busy_ff,     nxt_busy;
   logic       start_ff,    nxt_start;
   logic [7:0] rdata_ff,    nxt_rdata;
   logic [4:0] addr;
   logic       wr_chan;
   logic [7:0] clr_ready;
   logic       clr_die;
   logic       clr_sup;

   function automatic logic [2:0] result_index(input logic [4:0] a);
      logic [4:0] off;
      off = a - mon_regs_pkg::ADDR_RESULT_FIRST;
      result_index = off[3:1];
   endfunction

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   always_comb begin
      addr      = host_req.addr[mon_regs_pkg::ADDR_USED_BITS-1:0];
      wr_chan   = host_req.wr && (addr == mon_regs_pkg::ADDR_CHANNEL_STATE);
      clr_ready = 8'h00;
      clr_die   = 1'b0;
      clr_sup   = 1'b0;
      // Addressing a result register (MSB byte) clears its flag
      if ((host_req.rd || host_req.wr) && addr >= mon_regs_pkg::ADDR_RESULT_FIRST
          && addr <= 5'h19 && !addr[0]) begin
         clr_ready[result_index(addr)] = 1'b1;
      end
      if ((host_req.rd || host_req.wr) && addr == 5'h1A) begin
         clr_die = 1'b1;
      end
      if ((host_req.rd || host_req.wr) && addr == 5'h1C) begin
         clr_sup = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_ready   = (ready_ff & ~clr_ready) | result_written;
      nxt_die_new = (die_new_ff & ~clr_die) | die_temp_written;
      nxt_sup_new = (sup_new_ff & ~clr_sup) | supply_written;
      nxt_chan    = chan_ff;
      nxt_pcfg_a  = pcfg_a_ff;
      nxt_pcfg_b  = pcfg_b_ff;
      nxt_pwmc    = pwmc_ff;
      nxt_start   = wr_chan;
      if (host_req.wr) begin
         unique case (addr)
            mon_regs_pkg::ADDR_CHANNEL_STATE:
               nxt_chan = host_req.wdata & mon_regs_pkg::CH_WRITE_MASK;
            mon_regs_pkg::ADDR_PAIRS_ONE_TWO:
               nxt_pcfg_a = host_req.wdata;
            mon_regs_pkg::ADDR_PAIRS_3_4:
               nxt_pcfg_b = host_req.wdata;
            mon_regs_pkg::ADDR_PWM_DIE:
               nxt_pwmc = host_req.wdata & mon_regs_pkg::PW_WRITE_MASK;
            default: begin
               nxt_chan = chan_ff;
            end
         endcase
      end
      // Busy: set on trigger, held in repeated mode, dropped at end of single shot
      nxt_busy = busy_ff;
      if (wr_chan) begin
         nxt_busy = 1'b1;
      end else if (conv_done && !pwmc_ff[mon_regs_pkg::PW_REPEAT]) begin
         nxt_busy = 1'b0;
      end
      unique case (addr)
         mon_regs_pkg::ADDR_RESULT_READY:  nxt_rdata = ready_ff;
         mon_regs_pkg::ADDR_CHANNEL_STATE: nxt_rdata = {chan_ff[7:3], busy_ff,
                                                        die_new_ff, sup_new_ff};
         mon_regs_pkg::ADDR_PAIRS_ONE_TWO: nxt_rdata = pcfg_a_ff;
         mon_regs_pkg::ADDR_PAIRS_3_4:     nxt_rdata = pcfg_b_ff;
         mon_regs_pkg::ADDR_PWM_DIE:       nxt_rdata = pwmc_ff;
         default:                          nxt_rdata = 8'h00;
      endcase
      if (!host_req.rd) begin
         nxt_rdata = rdata_ff;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ready_ff   <= mon_regs_pkg::REG_RESET;
         chan_ff    <= mon_regs_pkg::REG_RESET;
         pcfg_a_ff  <= mon_regs_pkg::REG_RESET;
         pcfg_b_ff  <= mon_regs_pkg::REG_RESET;
         pwmc_ff    <= mon_regs_pkg::REG_RESET;
         rdata_ff   <= mon_regs_pkg::REG_RESET;
         die_new_ff <= 1'b0;
         sup_new_ff <= 1'b0;
         busy_ff    <= 1'b0;
         start_ff   <= 1'b0;
      end else begin
         ready_ff   <= nxt_ready;
         chan_ff    <= nxt_chan;
         pcfg_a_ff  <= nxt_pcfg_a;
         pcfg_b_ff  <= nxt_pcfg_b;
         pwmc_ff    <= nxt_pwmc;
         rdata_ff   <= nxt_rdata;
         die_new_ff <= nxt_die_new;
         sup_new_ff <= nxt_sup_new;
         busy_ff    <= nxt_busy;
         start_ff   <= nxt_start;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata         = rdata_ff;
   assign conv_start    = start_ff;
   assign conv_busy     = busy_ff;
   assign repeat_mode   = pwmc_ff[mon_regs_pkg::PW_REPEAT];
   assign pair_enable   = chan_ff[7:mon_regs_pkg::CH_PAIR_EN_LSB];
   assign die_enable    = chan_ff[mon_regs_pkg::CH_DIE_EN];
   assign die_filter_en = pwmc_ff[mon_regs_pkg::PW_DIE_FILT];
   assign die_kelvin    = pwmc_ff[mon_regs_pkg::PW_DIE_KELVIN];

   pair_decode u_pair0 (.nibble(pcfg_a_ff[3:0]), .cfg(pair_cfg[0]));
   pair_decode u_pair1 (.nibble(pcfg_a_ff[7:4]), .cfg(pair_cfg[1]));
   pair_decode u_pair2 (.nibble(pcfg_b_ff[3:0]), .cfg(pair_cfg[2]));
   pair_decode u_pair3 (.nibble(pcfg_b_ff[7:4]), .cfg(pair_cfg[3]));

   pwm_gen u_pwm (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .enable     (pwmc_ff[mon_regs_pkg::PW_ENABLE]),
      .invert     (pwmc_ff[mon_regs_pkg::PW_INVERT]),
      .threshold  ({pwm_thr_msb, pwmc_ff[mon_regs_pkg::PW_THR_LSB]}),
      .temp_level (pwm_temp_level),
      .pwm_out    (pwm_out)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_chan_write;
      host_req.wr && (host_req.addr[4:0] == 5'h01);
   endsequence

   chk_trigger_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      s_chan_write |=> conv_start && conv_busy)
      else $error("write to channel register did not trigger");
   chk_addr_alias: assert property (@(posedge clk_sys) disable iff (rst)
      (host_req.wr && host_req.addr[4:0] == 5'h08) |=>
      (pwmc_ff == ($past(host_req.wdata) & 8'hFC)))
      else $error("upper address bits not ignored");
   chk_flag_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
      result_written[0] |=> ready_ff[0])
      else $error("new result flag lost");
   chk_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
      (host_req.rd && host_req.addr[4:0] == 5'h0A && !result_written[0]) |=> !ready_ff[0])
      else $error("result flag not cleared on access");
   chk_repeat_busy: assert property (@(posedge clk_sys) disable iff (rst)
      (busy_ff && repeat_mode && !(host_req.wr && host_req.addr[4:0] == 5'h08)) |=> busy_ff)
      else $error("busy dropped in repeated mode");
   chk_single_done: assert property (@(posedge clk_sys) disable iff (rst)
      (conv_done && !repeat_mode && !wr_chan) |=> !conv_busy)
      else $error("busy not released after single shot");
   chk_pwm_idle: assert property (@(posedge clk_sys) disable iff (rst)
      (!pwmc_ff[5] ##1 !pwmc_ff[5]) |-> (pwm_out == $past(pwmc_ff[6])))
      else $error("disabled pwm pin level wrong");
   chk_ro_bits: assert property (@(posedge clk_sys) disable iff (rst)
      chan_ff[2:0] == 3'b000 && pwmc_ff[1:0] == 2'b00)
      else $error("read-only or reserved bits stored");
   chk_reset_zero: assert property (@(posedge clk_sys) disable iff (rst)
      $past(rst) |-> (chan_ff == 8'h00 && ready_ff == 8'h00 && !busy_ff))
      else $error("register not zero after reset");

endmodule

/* conv_engine_model.sv */
`timescale 1ns/1ps
module conv_engine_model #(
   parameter int DELAY = 6
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Controls from the bank
   input  wire logic       conv_start,
   input  wire logic       repeat_mode,
   input  wire logic [3:0] pair_enable,
   input  wire logic       die_enable,
   // Results back to the bank
   output      logic [7:0] result_written   = 8'h00,
   output      logic       die_temp_written = 1'b0,
   output      logic       supply_written   = 1'b0,
   output      logic       conv_done        = 1'b0
);
   int cnt = 0;

   // ------------------------------------------------------------
   // Sequence: fixed delay, then one pulse per enabled result
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      result_written   <= 8'h00;
      die_temp_written <= 1'b0;
      supply_written   <= 1'b0;
      conv_done        <= 1'b0;
      if (rst) begin
         cnt <= 0;
      end else if (conv_start) begin
         cnt <= DELAY;
      end else if (cnt == 1) begin
         for (int k = 0; k < 4; k++) begin
            result_written[2*k +: 2] <= {2{pair_enable[k]}};
         end
         die_temp_written <= die_enable;
         supply_written   <= die_enable;
         conv_done        <= 1'b1;
         // Repeated acquisition keeps the engine cycling
         cnt              <= repeat_mode ? DELAY : 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   localparam int DELAY = 6;

   logic                    clk_sys;
   logic                    rst            = 1'b1;
   mon_regs_pkg::host_req_s host_req       = '0;
   logic [7:0]              rdata;
   logic [7:0]              result_written;
   logic                    die_temp_written;
   logic                    supply_written;
   logic                    conv_done;
   logic [8:0]              pwm_temp_level = 9'h000;
   logic [7:0]              pwm_thr_msb    = 8'h00;
   logic                    conv_start;
   logic                    conv_busy;
   logic                    repeat_mode;
   logic [3:0]              pair_enable;
   logic                    die_enable;
   logic                    die_filter_en;
   logic                    die_kelvin;
   mon_regs_pkg::pair_cfg_s pair_cfg [4];
   logic                    pwm_out;
   int                      num_errors     = 0;
   int                      checks         = 0;

   // ------------------------------------------------------------
   // Design and conversion engine
   // ------------------------------------------------------------
   mon_regs DUT (
      .clk_sys(clk_sys), .rst(rst), .host_req(host_req), .rdata(rdata),
      .result_written(result_written), .die_temp_written(die_temp_written),
      .supply_written(supply_written), .conv_done(conv_done),
      .pwm_temp_level(pwm_temp_level), .pwm_thr_msb(pwm_thr_msb),
      .conv_start(conv_start), .conv_busy(conv_busy), .repeat_mode(repeat_mode),
      .pair_enable(pair_enable), .die_enable(die_enable),
      .die_filter_en(die_filter_en), .die_kelvin(die_kelvin),
      .pair_cfg(pair_cfg), .pwm_out(pwm_out)
   );

   conv_engine_model #(.DELAY(DELAY)) engine (
      .clk_sys(clk_sys), .rst(rst), .conv_start(conv_start),
      .repeat_mode(repeat_mode), .pair_enable(pair_enable),
      .die_enable(die_enable), .result_written(result_written),
      .die_temp_written(die_temp_written), .supply_written(supply_written),
      .conv_done(conv_done)
   );

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // ------------------------------------------------------------
   // Bus access and comparison
   // ------------------------------------------------------------
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      host_req <= '0;
      #1;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_sys);
      host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      host_req <= '0;
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      rd_reg(a);
      cmp(16'(rdata), 16'(exp));
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] addrs [5] = '{8'h00, 8'h01, 8'h06, 8'h07, 8'h08};
      foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
      cmp(16'({conv_busy, repeat_mode, pair_enable, die_enable, pwm_out}), 16'h0000);
   endtask

   task automatic t_pairs();
      wr_reg(8'hE6, 8'hA5);
      wr_reg(8'h07, 8'h5A);
      rd_chk(8'h06, 8'hA5);
      rd_chk(8'hA7, 8'h5A);
      cmp(16'(pair_cfg[0]), 16'h0005);
      cmp(16'(pair_cfg[1]), 16'h000A);
      cmp(16'(pair_cfg[2]), 16'h000A);
      cmp(16'(pair_cfg[3]), 16'h0005);
   endtask

   task automatic t_die_ctrl();
      wr_reg(8'h08, 8'hFF);
      rd_chk(8'h08, 8'hFC);
      cmp(16'({repeat_mode, die_filter_en, die_kelvin}), 16'h0007);
      wr_reg(8'h08, 8'h00);
      cmp(16'({repeat_mode, die_filter_en, die_kelvin}), 16'h0000);
   endtask

   task automatic t_trigger();
      wr_reg(8'h01, 8'hFF);
      cmp(16'({conv_start, conv_busy}), 16'h0003);
      cmp(16'({pair_enable, die_enable}), 16'h001F);
      @(posedge clk_sys);
      #1;
      cmp(16'(conv_start), 16'h0000);
      repeat (DELAY + 3) @(posedge clk_sys);
      #1;
      cmp(16'(conv_busy), 16'h0000);
      rd_chk(8'h00, 8'hFF);
      rd_chk(8'h01, 8'hFB);
      wr_reg(8'h00, 8'h00);
      rd_reg(8'h0A);
      rd_reg(8'h1A);
      rd_reg(8'h1C);
      rd_chk(8'h00, 8'hFE);
      rd_chk(8'h01, 8'hF8);
      wr_reg(8'h03, 8'hFF);
      rd_chk(8'h03, 8'h00);
      rd_chk(8'h06, 8'hA5);
   endtask

   task automatic t_repeat();
      wr_reg(8'h08, 8'h10);
      wr_reg(8'h21, 8'h00);
      cmp(16'(conv_start), 16'h0001);
      repeat (3 * DELAY) @(posedge clk_sys);
      #1;
      cmp(16'(conv_busy), 16'h0001);
      wr_reg(8'h08, 8'h00);
      repeat (DELAY + 3) @(posedge clk_sys);
      #1;
      cmp(16'(conv_busy), 16'h0000);
   endtask

   task automatic pwm_duty(input logic [7:0] ctl, input logic [8:0] lvl,
                           input logic [9:0] exp);
      int n;
      wr_reg(8'h08, ctl);
      @(posedge clk_sys);
      pwm_temp_level <= lvl;
      repeat (512) @(posedge clk_sys);
      n = 0;
      repeat (512) begin
         @(posedge clk_sys);
         #1;
         n += int'(pwm_out === 1'b1);
      end
      cmp(16'(n), 16'(exp));
   endtask

   task automatic t_pwm();
      pwm_duty(8'h20, 9'h100, 10'h100);
      pwm_duty(8'h20, 9'h080, 10'h080);
      pwm_duty(8'hA0, 9'h080, 10'h07F);
      pwm_duty(8'h60, 9'h080, 10'h180);
      pwm_duty(8'h00, 9'h100, 10'h000);
      pwm_duty(8'h40, 9'h100, 10'h200);
   endtask

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_pairs();
      t_die_ctrl();
      t_trigger();
      t_repeat();
      t_pwm();
      conclude();
   end

   // Run takes about 6300 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      conclude();
   end
endmodule
